// File: bench/diag_host_model.sv
`timescale 1ns/10ps
// Host side: plain register port with one-cycle strobes and record reads
module diag_host_model
    import diag_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic [31:0] i_rdata,
    output logic [7:0]       o_addr,
    output logic [31:0]      o_wdata,
    output logic             o_wr,
    output logic             o_rd
);
    // Bus idles with strobes low from time zero
    initial begin
        o_addr = 8'h00;
        o_wdata = 32'h0;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // Idle address and data are inverted so stale values never look valid
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_sys_clk);
        o_wr    <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~d;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_sys_clk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_sys_clk);
        o_rd   <= 1'b0;
        o_addr <= ~a;
        #1 d = i_rdata;
    endtask
    // Record read: request the record number, then fetch its snapshot
    // Write and read go back to back, with no idle cycle between the strobes
    task automatic rec_read(input logic [7:0] n, output logic [31:0] d);
        @(posedge i_sys_clk);
        o_addr  <= ADDR_RECORD_REQ;
        o_wdata <= {24'h0, n};
        o_wr    <= 1'b1;
        @(posedge i_sys_clk);
        o_wr    <= 1'b0;
        o_addr  <= ADDR_RECORD_DATA;
        o_rd    <= 1'b1;
        @(posedge i_sys_clk);
        o_rd    <= 1'b0;
        o_addr  <= ~ADDR_RECORD_DATA;
        #1 d = i_rdata;
    endtask
endmodule

// File: bench/tb_diag_status_indicator.sv
`timescale 1ns/10ps
module tb_diag_status_indicator;
    import diag_pkg::*;
    logic sys_clk = 1'b0, resetn = 1'b0, bp = 1'b0, load = 1'b0, run_ind, err_ind, sup_ind, alm;
    logic [3:0] sh = 4'h0, wb = 4'h0, ov = 4'h0, un = 4'h0, ch_ind, ch_alm, vstat;
    logic [7:0] addr, alm_code;
    logic [2:0] alm_src;
    logic [31:0] wdata, rdata, d;
    logic wr, rd;
    int n_errors = 0, n_checks = 0, cyc = 0, tr, te;
    localparam logic [7:0] CODES [4] = '{CODE_SHORT, CODE_WIRE, CODE_OVER, CODE_UNDER};
    // 10 MHz clock
    always #50 sys_clk = ~sys_clk;
    diag_status_indicator #(.FLASH_HALF(4)) u_diag_status_indicator (.i_sys_clk(sys_clk), .i_resetn(resetn),
        .i_backplane_ok(bp), .i_load_supply_ok(load), .i_short_fault(sh), .i_wire_break(wb), .i_overflow(ov),
        .i_underflow(un), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_run_indicator(run_ind), .o_error_indicator(err_ind), .o_supply_indicator(sup_ind),
        .o_channel_indicator(ch_ind), .o_channel_alarm_indicator(ch_alm), .o_value_status_bit(vstat),
        .o_diag_alarm(alm), .o_alarm_code(alm_code), .o_alarm_source(alm_src));
    diag_host_model u_diag_host_model (.i_sys_clk(sys_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Count lamp transitions over 20 cycles, five flash half periods
    task automatic watch(output int t_run, output int t_err);
        logic pr, pe;
        t_run = 0;
        t_err = 0;
        repeat (20) begin
            pr = run_ind;
            pe = err_ind;
            @(posedge sys_clk);
            #1;
            t_run += (run_ind !== pr);
            t_err += (err_ind !== pe);
        end
    endtask
    // Bounded wait for the alarm pulse, then its code and source
    task automatic wait_alarm(input logic [7:0] code, input logic [2:0] src);
        for (int i = 0; i < 12 && alm !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        chk("diag_alarm", 32'h1, {31'h0, alm});
        chk("alarm_code", {24'h0, code}, {24'h0, alm_code});
        chk("alarm_source", {29'h0, src}, {29'h0, alm_src});
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 3000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (8) @(posedge sys_clk);
        #1 chk("run_dark", 32'h0, {31'h0, run_ind});
        chk("err_dark", 32'h0, {31'h0, err_ind});
        @(posedge sys_clk);
        {bp, load} <= 2'b11;
        repeat (6) @(posedge sys_clk);
        watch(tr, te);
        chk("start_flash", 32'h1, {31'h0, tr > 2 && te == 0 && err_ind === 1'b0});
        u_diag_host_model.wr_reg(ADDR_CTRL, 32'h0000_00F1);
        repeat (3) @(posedge sys_clk);
        watch(tr, te);
        chk("run_steady", 32'h1, {31'h0, tr == 0 && te == 0 && run_ind === 1'b1 && err_ind === 1'b0});
        chk("supply_on", 32'h1, {31'h0, sup_ind});
        chk("chan_lit", 32'hF, {28'h0, ch_ind});
        chk("value_status", 32'hF, {28'h0, vstat});
        $display("test startup done");
        // One fault kind per channel: short ch0, wire ch1, over ch2, under ch3
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            {un, ov, wb, sh} <= 16'h1 << (5 * k);
            wait_alarm(CODES[k], k[2:0]);
            @(posedge sys_clk);
            #1 chk("chan_alarm", {31'h0, k > 0}, {31'h0, ch_alm[k]});
            chk("vstat_low", 32'h0, {31'h0, vstat[k]});
            watch(tr, te);
            chk("err_flash", 32'h1, {31'h0, tr == 0 && te > 2 && run_ind === 1'b1});
            u_diag_host_model.rec_read(RECORD_CHANNEL, d);
            chk("record1", {24'h0, CODES[k]} << (8 * k), d);
            @(posedge sys_clk);
            {un, ov, wb, sh} <= 16'h0;
            repeat (8) @(posedge sys_clk);
        end
        $display("test channel faults done");
        u_diag_host_model.wr_reg(ADDR_CTRL, 32'h0000_02F1);
        wait_alarm(8'h10, 3'd1);
        u_diag_host_model.wr_reg(ADDR_CTRL, 32'h0000_00F1);
        @(posedge sys_clk);
        load <= 1'b0;
        wait_alarm(8'h11, 3'd4);
        repeat (2) @(posedge sys_clk);
        #1 chk("supply_off", 32'h0, {31'h0, sup_ind});
        u_diag_host_model.rd_reg(ADDR_ALARM_INFO, d);
        chk("alarm_info", {15'h0, 1'b1, 5'h0, 3'h4, CODE_LOAD}, d);
        u_diag_host_model.rec_read(RECORD_MODULE, d);
        chk("record0_load", 32'h2, d & 32'h2);
        @(posedge sys_clk);
        load <= 1'b1;
        u_diag_host_model.wr_reg(ADDR_CTRL, 32'h0000_0001);
        repeat (6) @(posedge sys_clk);
        #1 chk("chan_off", 32'h0, {28'h0, ch_ind});
        u_diag_host_model.rd_reg(8'hFC, d);
        chk("unmapped", 32'h0, d);
        u_diag_host_model.rec_read(8'h05, d);
        chk("record_bad_data", 32'h0, d);
        // Backplane, load and parameters good, bad record flagged, channels off
        u_diag_host_model.rd_reg(ADDR_STATUS, d);
        chk("status", 32'h0000_1007, d);
        $display("test supply and access done");
        @(posedge sys_clk);
        bp <= 1'b0;
        repeat (8) @(posedge sys_clk);
        #1 chk("bp_lost", 32'h0, {30'h0, run_ind, err_ind});
        $display("test backplane loss done");
        print_verdict();
    end
endmodule

// File: hw/diag_status_indicator.sv
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module diag_status_indicator
    import diag_pkg::*;
#(
    parameter int FLASH_HALF = FLASH_HALF_CYCLES
) (
    input  wire logic                i_sys_clk,
    input  wire logic                i_resetn,
    input  wire logic                i_backplane_ok,
    input  wire logic                i_load_supply_ok,
    input  wire logic [NUM_CHAN-1:0] i_short_fault,
    input  wire logic [NUM_CHAN-1:0] i_wire_break,
    input  wire logic [NUM_CHAN-1:0] i_overflow,
    input  wire logic [NUM_CHAN-1:0] i_underflow,
    input  wire logic [7:0]          i_addr,
    input  wire logic [31:0]         i_wdata,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    output logic [31:0]              o_rdata,
    output logic                     o_run_indicator,
    output logic                     o_error_indicator,
    output logic                     o_supply_indicator,
    output logic [NUM_CHAN-1:0]      o_channel_indicator,
    output logic [NUM_CHAN-1:0]      o_channel_alarm_indicator,
    output logic [NUM_CHAN-1:0]      o_value_status_bit,
    output logic                     o_diag_alarm,
    output logic [7:0]               o_alarm_code,
    output logic [2:0]               o_alarm_source
);

    typedef struct packed {
        logic [SYNC_W-1:0]             sync1;
        logic [SYNC_W-1:0]             sync2;
        logic [SYNC_W-1:0]             sync3;
        logic [SYNC_W-1:0]             filt;
        logic                          param_valid;
        logic [NUM_CHAN-1:0]           chan_en;
        logic [NUM_CHAN-1:0]           param_err;
        logic [NUM_SRC-1:0][7:0]       prev_code;
        logic [NUM_SRC-1:0]            pend;
        logic [NUM_SRC-1:0][7:0]       pend_code;
        logic                          alarm;
        logic [7:0]                    alarm_code;
        logic [2:0]                    alarm_src;
        logic [7:0]                    info_code;
        logic [2:0]                    info_src;
        logic                          info_valid;
        logic [31:0]                   record_data;
        logic                          record_bad;
        logic [31:0]                   rdata;
        logic                          run;
        logic                          err;
        logic                          supply;
        logic [NUM_CHAN-1:0]           ch_ind;
        logic [NUM_CHAN-1:0]           ch_alm;
        logic [NUM_CHAN-1:0]           vstat;
    } diag_state_type;

    diag_state_type st_ff;
    diag_state_type nxt_st;

    logic                    flash_level;
    logic [NUM_SRC-1:0][7:0] code;
    logic [NUM_SRC-1:0]      onset;
    logic [NUM_SRC-1:0]      clr;
    logic [NUM_CHAN-1:0]     alm_ch;
    logic [NUM_CHAN-1:0]     short_f;
    logic [NUM_CHAN-1:0]     wire_f;
    logic                    any_fault;
    logic                    bp_ok;
    logic                    load_ok;
    logic                    found;
    logic [2:0]              pick;
    logic [SYNC_W-1:0]       agree;
    logic [31:0]             rec0;
    logic [31:0]             rec1;

    // One shared flash source keeps all flashing indicators in phase
    flash_timer #(
        .FLASH_HALF (FLASH_HALF)
    ) u_flash (
        .i_sys_clk     (i_sys_clk),
        .i_resetn      (i_resetn),
        .o_flash_level (flash_level)
    );

    // Whole block state update: pin filtering, codes, alarms, indicators, registers
    always_comb begin
        nxt_st = st_ff;

        // Three-stage capture; a level counts once the last two stages agree
        nxt_st.sync1 = {i_wire_break, i_short_fault, i_load_supply_ok, i_backplane_ok};
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.sync3 = st_ff.sync2;
        agree        = ~(st_ff.sync2 ^ st_ff.sync3);
        nxt_st.filt  = (agree & st_ff.sync3) | (~agree & st_ff.filt);

        bp_ok   = st_ff.filt[PIN_BP];
        load_ok = st_ff.filt[PIN_LOAD];
        short_f = st_ff.filt[PIN_SHORT +: NUM_CHAN];
        wire_f  = st_ff.filt[PIN_WIRE +: NUM_CHAN];

        // Per-channel code; parameter trouble masks the analog faults behind it
        for (int c = 0; c < NUM_CHAN; c++) begin
            if (!st_ff.chan_en[c]) begin
                code[c] = CODE_NONE;
            end else if (st_ff.param_err[c]) begin
                code[c] = CODE_PARAM;
            end else if (short_f[c]) begin
                code[c] = CODE_SHORT;
            end else if (wire_f[c]) begin
                code[c] = CODE_WIRE;
            end else if (i_overflow[c]) begin
                code[c] = CODE_OVER;
            end else if (i_underflow[c]) begin
                code[c] = CODE_UNDER;
            end else begin
                code[c] = CODE_NONE;
            end
            alm_ch[c] = st_ff.chan_en[c] & (wire_f[c] | i_overflow[c] | i_underflow[c]);
        end
        // Load loss only means something while the backplane powers us
        code[SRC_LOAD] = (bp_ok && !load_ok) ? CODE_LOAD : CODE_NONE;

        any_fault = 1'b0;
        for (int s = 0; s < NUM_SRC; s++) begin
            any_fault = any_fault | (code[s] != CODE_NONE);
            onset[s]  = (code[s] != CODE_NONE) && (code[s] != st_ff.prev_code[s]);
        end
        nxt_st.prev_code = code;

        // Lowest pending source is reported first, one alarm per cycle
        found = 1'b0;
        pick  = 3'h0;
        for (int s = NUM_SRC - 1; s >= 0; s--) begin
            if (st_ff.pend[s]) begin
                found = 1'b1;
                pick  = 3'(s);
            end
        end
        clr = '0;
        if (found) begin
            clr[pick] = 1'b1;
        end
        // A new event in the same cycle as the report keeps its pending bit
        nxt_st.pend = (st_ff.pend & ~clr) | onset;
        for (int s = 0; s < NUM_SRC; s++) begin
            if (onset[s]) begin
                nxt_st.pend_code[s] = code[s];
            end
        end
        nxt_st.alarm      = found;
        nxt_st.alarm_code = found ? st_ff.pend_code[pick] : CODE_NONE;
        nxt_st.alarm_src  = found ? pick : 3'h0;

        // Run and error indicators
        if (!bp_ok) begin
            nxt_st.run = 1'b0;
            nxt_st.err = 1'b0;
        end else if (!st_ff.param_valid) begin
            nxt_st.run = flash_level;
            nxt_st.err = 1'b0;
        end else if (any_fault) begin
            nxt_st.run = 1'b1;
            nxt_st.err = flash_level;
        end else begin
            nxt_st.run = 1'b1;
            nxt_st.err = 1'b0;
        end
        nxt_st.supply = load_ok;

        // Channel lamps and value status; a dead load supply clears every value status bit
        for (int c = 0; c < NUM_CHAN; c++) begin
            nxt_st.ch_ind[c] = st_ff.chan_en[c] && (code[c] == CODE_NONE);
            nxt_st.ch_alm[c] = alm_ch[c];
            nxt_st.vstat[c]  = st_ff.chan_en[c] && (code[c] == CODE_NONE) && load_ok;
        end

        // Diagnostic records served to the host
        rec0 = '0;
        rec0[0]             = any_fault;
        rec0[REC0_LOAD_BIT] = (code[SRC_LOAD] != CODE_NONE);
        rec0[REC0_NOPV_BIT] = ~st_ff.param_valid;
        for (int c = 0; c < NUM_CHAN; c++) begin
            rec0[REC0_CH_LSB + c] = (code[c] != CODE_NONE);
        end
        rec1 = {code[3], code[2], code[1], code[0]};

        // Register writes
        if (i_wr) begin
            case (i_addr)
                ADDR_CTRL: begin
                    nxt_st.param_valid = i_wdata[CTRL_PV_BIT];
                    nxt_st.chan_en     = i_wdata[CTRL_EN_LSB +: NUM_CHAN];
                    nxt_st.param_err   = i_wdata[CTRL_PERR_LSB +: NUM_CHAN];
                end
                ADDR_RECORD_REQ: begin
                    case (i_wdata[7:0])
                        RECORD_MODULE: begin
                            nxt_st.record_data = rec0;
                            nxt_st.record_bad  = 1'b0;
                        end
                        RECORD_CHANNEL: begin
                            nxt_st.record_data = rec1;
                            nxt_st.record_bad  = 1'b0;
                        end
                        default: begin
                            nxt_st.record_data = '0;
                            nxt_st.record_bad  = 1'b1;
                        end
                    endcase
                end
                ADDR_ALARM_INFO: begin
                    if (i_wdata[AI_VALID_BIT]) begin
                        nxt_st.info_valid = 1'b0;
                    end
                end
                default: begin
                    nxt_st.record_bad = st_ff.record_bad;
                end
            endcase
        end

        // Latest alarm is kept for the host; the set beats a clear
        if (found) begin
            nxt_st.info_valid = 1'b1;
            nxt_st.info_code  = st_ff.pend_code[pick];
            nxt_st.info_src   = pick;
        end

        // Read data stand for exactly one cycle after the strobe
        nxt_st.rdata = '0;
        if (i_rd) begin
            case (i_addr)
                ADDR_CTRL: begin
                    nxt_st.rdata[CTRL_PV_BIT]                = st_ff.param_valid;
                    nxt_st.rdata[CTRL_EN_LSB +: NUM_CHAN]   = st_ff.chan_en;
                    nxt_st.rdata[CTRL_PERR_LSB +: NUM_CHAN] = st_ff.param_err;
                end
                ADDR_STATUS: begin
                    nxt_st.rdata[ST_BP_BIT]                = bp_ok;
                    nxt_st.rdata[ST_LOAD_BIT]              = load_ok;
                    nxt_st.rdata[ST_PV_BIT]                = st_ff.param_valid;
                    nxt_st.rdata[ST_FAULT_BIT]             = any_fault;
                    nxt_st.rdata[ST_VSTAT_LSB +: NUM_CHAN] = st_ff.vstat;
                    nxt_st.rdata[ST_CHALM_LSB +: NUM_CHAN] = st_ff.ch_alm;
                    nxt_st.rdata[ST_RECBAD_BIT]            = st_ff.record_bad;
                end
                ADDR_ALARM_INFO: begin
                    nxt_st.rdata[7:0]                 = st_ff.info_code;
                    nxt_st.rdata[AI_SRC_LSB +: 3]     = st_ff.info_src;
                    nxt_st.rdata[AI_VALID_BIT]        = st_ff.info_valid;
                end
                ADDR_RECORD_DATA: begin
                    nxt_st.rdata = st_ff.record_data;
                end
                default: begin
                    nxt_st.rdata = '0;
                end
            endcase
        end
    end

    // All state in one register; indicators start dark
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs come straight from the state register
    assign o_rdata                   = st_ff.rdata;
    assign o_run_indicator           = st_ff.run;
    assign o_error_indicator         = st_ff.err;
    assign o_supply_indicator        = st_ff.supply;
    assign o_channel_indicator       = st_ff.ch_ind;
    assign o_channel_alarm_indicator = st_ff.ch_alm;
    assign o_value_status_bit        = st_ff.vstat;
    assign o_diag_alarm              = st_ff.alarm;
    assign o_alarm_code              = st_ff.alarm_code;
    assign o_alarm_source            = st_ff.alarm_src;

    // Checks next to the logic they guard
    chk_backplane_dark: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        !bp_ok |=> (!o_run_indicator && !o_error_indicator))
        else $error("indicators lit without backplane supply");
    chk_startup_flash: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (bp_ok && !st_ff.param_valid) |=> (o_run_indicator == $past(flash_level) && !o_error_indicator))
        else $error("run indicator not flashing during startup");
    chk_fault_flash: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (bp_ok && st_ff.param_valid && any_fault)
        |=> (o_run_indicator && o_error_indicator == $past(flash_level)))
        else $error("error indicator not flashing on fault");
    chk_supply_lamp: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        1'b1 |=> (o_supply_indicator == $past(load_ok)))
        else $error("supply indicator does not follow load supply");
    chk_channel_off: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        1'b1 |=> ((o_channel_indicator & ~$past(st_ff.chan_en)) == '0))
        else $error("deactivated channel indicator lit");
    chk_wire_alarm_lamp: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (st_ff.chan_en[0] && wire_f[0]) |=> o_channel_alarm_indicator[0])
        else $error("channel alarm indication missing on wire break");
    chk_alarm_raised: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (onset != '0) |-> ##[1:6] o_diag_alarm)
        else $error("diagnostic event gave no alarm");
    chk_alarm_coded: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        o_diag_alarm |-> (o_alarm_code != CODE_NONE))
        else $error("alarm without error code");
    chk_short_code: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (st_ff.chan_en[0] && !st_ff.param_err[0] && short_f[0] && onset[0])
        |-> ##[1:6] (o_diag_alarm && o_alarm_source == 3'h0 && o_alarm_code == CODE_SHORT))
        else $error("short not reported with its code");
    chk_wire_code: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (onset[1] && st_ff.chan_en[1] && !st_ff.param_err[1] && !short_f[1] && wire_f[1])
        |-> ##[1:6] (o_diag_alarm && o_alarm_source == 3'h1 && o_alarm_code == CODE_WIRE))
        else $error("wire break not reported with its code");
    chk_over_code: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (onset[2] && st_ff.chan_en[2] && !st_ff.param_err[2] && !short_f[2] && !wire_f[2] && i_overflow[2])
        |-> ##[1:6] (o_diag_alarm && o_alarm_source == 3'h2 && o_alarm_code == CODE_OVER))
        else $error("overflow not reported with its code");
    chk_under_code: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (onset[3] && st_ff.chan_en[3] && !st_ff.param_err[3] && !short_f[3] && !wire_f[3]
            && !i_overflow[3] && i_underflow[3])
        |-> ##[1:6] (o_diag_alarm && o_alarm_source == 3'h3 && o_alarm_code == CODE_UNDER))
        else $error("underflow not reported with its code");
    chk_param_code: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (onset[1] && st_ff.chan_en[1] && st_ff.param_err[1])
        |-> ##[1:6] (o_diag_alarm && o_alarm_source == 3'h1 && o_alarm_code == CODE_PARAM))
        else $error("parameter error not reported with its code");
    chk_load_code: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        onset[SRC_LOAD] |-> ##[1:6] (o_diag_alarm && o_alarm_code == CODE_LOAD))
        else $error("load loss not reported with its code");
    chk_record_read: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (i_wr && i_addr == ADDR_RECORD_REQ && i_wdata[7:0] == RECORD_CHANNEL)
        ##1 (i_rd && i_addr == ADDR_RECORD_DATA) |=> (o_rdata == $past(st_ff.record_data, 1)))
        else $error("record data not returned");
    chk_value_status: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (code[1] != CODE_NONE) |=> !o_value_status_bit[1])
        else $error("value status set on faulty channel");

    cov_alarm: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) o_diag_alarm);
    cov_error_flash: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
        o_run_indicator && $rose(o_error_indicator));
    cov_record: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_rd && i_addr == ADDR_RECORD_DATA && !st_ff.record_bad);
    cov_two_pending: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
        $countones(st_ff.pend) > 1);

endmodule

// File: hw/flash_timer.sv
`timescale 1ns/10ps
module flash_timer
    import diag_pkg::*;
#(
    parameter int FLASH_HALF = FLASH_HALF_CYCLES
) (
    input  wire logic i_sys_clk,
    input  wire logic i_resetn,
    output logic      o_flash_level
);

    typedef struct packed {
        logic [FLASH_CNT_W-1:0] cnt;
        logic                   level;
    } flash_state_type;

    localparam logic [FLASH_CNT_W-1:0] LAST_CNT = FLASH_CNT_W'(FLASH_HALF - 1);

    flash_state_type st_ff;
    flash_state_type nxt_st;

    // Free-running half-period counter; level flips at each wrap
    always_comb begin
        nxt_st = st_ff;
        if (st_ff.cnt == LAST_CNT) begin
            nxt_st.cnt   = '0;
            nxt_st.level = ~st_ff.level;
        end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
    end

    // Reset restarts the phase so every indicator flashes in step
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_flash_level = st_ff.level;

    chk_flash_half_period: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (st_ff.cnt == LAST_CNT) |=> (o_flash_level != $past(o_flash_level)))
        else $error("flash level did not flip at end of half period");
    chk_flash_steady: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (st_ff.cnt != LAST_CNT) |=> $stable(o_flash_level))
        else $error("flash level changed mid period");

endmodule

// File: shared/diag_pkg.sv
package diag_pkg;

    // Clock and flash timing
    localparam int CLK_PERIOD_NS     = 100;
    localparam int FLASH_HALF_NS     = 250_000_000;
    localparam int FLASH_HALF_CYCLES = FLASH_HALF_NS / CLK_PERIOD_NS;
    localparam int FLASH_CNT_W       = 22;

    // Channels and alarm sources (channels first, module load supply last)
    localparam int NUM_CHAN = 4;
    localparam int NUM_SRC  = 5;
    localparam int SRC_LOAD = 4;

    // Synchronised pin vector layout
    localparam int SYNC_W    = 10;
    localparam int PIN_BP    = 0;
    localparam int PIN_LOAD  = 1;
    localparam int PIN_SHORT = 2;
    localparam int PIN_WIRE  = 6;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL        = 8'h00;
    localparam logic [7:0] ADDR_STATUS      = 8'h04;
    localparam logic [7:0] ADDR_ALARM_INFO  = 8'h08;
    localparam logic [7:0] ADDR_RECORD_REQ  = 8'h0C;
    localparam logic [7:0] ADDR_RECORD_DATA = 8'h10;

    // Field positions
    localparam int CTRL_PV_BIT    = 0;
    localparam int CTRL_EN_LSB    = 4;
    localparam int CTRL_PERR_LSB  = 8;
    localparam int ST_BP_BIT      = 0;
    localparam int ST_LOAD_BIT    = 1;
    localparam int ST_PV_BIT      = 2;
    localparam int ST_FAULT_BIT   = 3;
    localparam int ST_VSTAT_LSB   = 4;
    localparam int ST_CHALM_LSB   = 8;
    localparam int ST_RECBAD_BIT  = 12;
    localparam int AI_SRC_LSB     = 8;
    localparam int AI_VALID_BIT   = 16;
    localparam int REC0_LOAD_BIT  = 1;
    localparam int REC0_NOPV_BIT  = 2;
    localparam int REC0_CH_LSB    = 4;

    // Error codes
    localparam logic [7:0] CODE_NONE  = 8'h00;
    localparam logic [7:0] CODE_SHORT = 8'h01;
    localparam logic [7:0] CODE_WIRE  = 8'h06;
    localparam logic [7:0] CODE_OVER  = 8'h07;
    localparam logic [7:0] CODE_UNDER = 8'h08;
    localparam logic [7:0] CODE_PARAM = 8'h10;
    localparam logic [7:0] CODE_LOAD  = 8'h11;

    // Record numbers
    localparam logic [7:0] RECORD_MODULE  = 8'h00;
    localparam logic [7:0] RECORD_CHANNEL = 8'h01;

endpackage
